// file: csl_consts.svh
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH

// ************************************************************
// register map, byte addresses on the avalon slave
// ************************************************************
`define CSL_OFS_RX_CTL 4'h0
`define CSL_OFS_RX_DATA 4'h4
`define CSL_OFS_TX_CTL 4'h8
`define CSL_OFS_TX_DATA 4'hC

// ************************************************************
// field positions
// ************************************************************
`define CSL_BIT_ERR_SUM 15
`define CSL_BIT_OVERRUN 14
`define CSL_BIT_FRAMING 13
`define CSL_BIT_RX_BREAK 11
`define CSL_BIT_RX_DONE 7
`define CSL_BIT_TX_READY 7
`define CSL_BIT_IRQ_EN 6
`define CSL_BIT_LOOPBACK 2
`define CSL_BIT_TX_BREAK 0
`define CSL_CHAR_MSB 7

// ************************************************************
// timing
// ************************************************************
`define CSL_CLK_HZ 25000000
`define CSL_BAUD_MIN 300
`define CSL_OVS 16
`define CSL_BREAK_BITS 20
`define CSL_DATA_BITS 8

// ************************************************************
// interrupt identity, held for the system interrupt logic
// ************************************************************
`define CSL_PRIO_LEVEL 8'h14
`define CSL_RX_VECTOR 8'hF8
`define CSL_TX_VECTOR 8'hFC

`endif

// file: csl_pkg.sv
package csl_pkg;

    // avalon-mm request as driven by the bus master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avs_req_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_STOP = 5'b01000,
        RX_BREAK = 5'b10000
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

endpackage : csl_pkg

// file: console_serial_line_unit.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "csl_consts.svh"

// Contract
// - receive data upper half reads zero
// - summary error is overrun or framing
// - overrun on unread overwrite, read clears
// - framing on bad stop bit, read clears
// - error flags re-evaluated at each character
// - break after twenty space bits, read clears
// - low byte holds last character, unused bits zero
// - ready clears on load, sets when free
// - ready set by reset and by supply drop while halted
// - transmit interrupt when enabled and ready
// - loopback: input mark, output feeds receiver
// - break holds space after current character
// - transmitter runs normally while break held
// - control bits cleared by reset events
// - low byte write is next character
// - upper data ignored, unused bits zero
// - receive flags cleared by reset events
// - eight data bits, no parity, one stop
// - done set on character, read clears
// - receive interrupt when enabled and done
// - one baud rate from three-bit code
module console_serial_line_unit
    import csl_pkg::*;
#(
    parameter int unsigned DIV_AT_MIN = `CSL_CLK_HZ / (`CSL_OVS * `CSL_BAUD_MIN)
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire avs_req_t i_avs,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_supply_good,
    input wire logic i_proc_halted,
    input wire logic [2:0] i_baud_code,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_rx_irq,
    output logic o_tx_irq
);

    // ********************************************************
    // reset events and bus decode
    // ********************************************************
    localparam logic [8:0] BREAK_TICKS = 9'(`CSL_BREAK_BITS * `CSL_OVS);
    localparam logic [3:0] OVS_LAST = 4'(`CSL_OVS - 1);
    localparam logic [3:0] OVS_MID = 4'(`CSL_OVS / 2 - 1);
    localparam logic [2:0] DATA_LAST = 3'(`CSL_DATA_BITS - 1);
    localparam logic [3:0] FRAME_LAST = 4'(`CSL_DATA_BITS + 1);

    logic good_q;
    logic ovs_tick;
    logic [12:0] div_cnt;
    rx_state_t rx_state;
    logic [3:0] rx_tick_cnt;
    logic [2:0] rx_bit_cnt;
    logic [7:0] rx_shift;
    logic [8:0] space_cnt;
    logic rx_q;
    logic [7:0] rx_char;
    logic rx_done, overrun, framing, rx_break, receive_interrupt_enable;
    tx_state_t tx_state;
    logic [7:0] tx_buf;
    logic [9:0] tx_frame;
    logic [3:0] tx_bit_cnt, tx_tick_cnt;
    logic tx_rdy, transmit_interrupt_enable, loopback, tx_break, brk_hold;
    logic [31:0] rx_ctl_word, rx_data_word, tx_ctl_word;

    // supply drop only counts while the processor is halted
    wire init_pulse = good_q & ~i_supply_good & i_proc_halted;
    wire bus_req = i_avs.read | i_avs.write;
    wire bus_ack = bus_req & o_avs_waitrequest;
    wire bus_take = bus_req & ~o_avs_waitrequest;
    wire lane0 = i_avs.byteenable[0];
    wire wr_ok = i_avs.write & bus_take & lane0;
    wire hit_rx_ctl = i_avs.address == `CSL_OFS_RX_CTL;
    wire hit_rx_data = i_avs.address == `CSL_OFS_RX_DATA;
    wire hit_tx_ctl = i_avs.address == `CSL_OFS_TX_CTL;
    wire hit_tx_data = i_avs.address == `CSL_OFS_TX_DATA;
    // clear on read happens where the data is captured, so no
    // flag set afterwards can be lost behind the master's sample
    wire rd_rx_data = i_avs.read & bus_ack & hit_rx_data;
    wire wr_tx_data = wr_ok & hit_tx_data;
    wire [12:0] div_lim = (13'(DIV_AT_MIN) >> i_baud_code) - 13'h0001;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            good_q <= 1'b0;
        end else begin
            good_q <= i_supply_good;
        end
    end

    // ********************************************************
    // oversampling divider shared by both directions
    // ********************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt <= 13'h0000;
            ovs_tick <= 1'b0;
        end else if (div_cnt >= div_lim) begin
            div_cnt <= 13'h0000;
            ovs_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 13'h0001;
            ovs_tick <= 1'b0;
        end
    end

    // ********************************************************
    // receiver
    // ********************************************************
    // in loopback the pin is ignored, as if it sat at mark
    wire rx_line = loopback ? o_serial_out : i_serial_in;
    wire rx_mid = ovs_tick & (rx_tick_cnt == OVS_LAST);
    wire char_evt = (rx_state == RX_STOP) & rx_mid;
    wire brk_evt = (rx_state == RX_BREAK) & ovs_tick & ~rx_q
        & (space_cnt == BREAK_TICKS - 9'h001);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_q <= 1'b1;
        end else begin
            rx_q <= rx_line;
        end
    end

    // count of consecutive space ticks; saturates so one long
    // space yields a single break, a mark must come in between
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            space_cnt <= 9'h000;
        end else if (ovs_tick) begin
            if (rx_q) begin
                space_cnt <= 9'h000;
            end else if (space_cnt != BREAK_TICKS) begin
                space_cnt <= space_cnt + 9'h001;
            end
        end
    end

    // frame walker, sampling at mid bit after the start edge
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_state <= RX_IDLE;
            rx_tick_cnt <= 4'h0;
            rx_bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
        end else if (init_pulse) begin
            rx_state <= RX_IDLE;
        end else if (ovs_tick) begin
            rx_tick_cnt <= rx_tick_cnt + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    rx_tick_cnt <= 4'h0;
                    if (!rx_q) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick_cnt == OVS_MID) begin
                        rx_tick_cnt <= 4'h0;
                        rx_bit_cnt <= 3'h0;
                        rx_state <= rx_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_tick_cnt == OVS_LAST) begin
                        rx_shift <= {rx_q, rx_shift[7:1]};
                        rx_bit_cnt <= rx_bit_cnt + 3'h1;
                        if (rx_bit_cnt == DATA_LAST) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tick_cnt == OVS_LAST) begin
                        rx_state <= rx_q ? RX_IDLE : RX_BREAK;
                    end
                end
                RX_BREAK: begin
                    // wait for mark so a held space is not a start
                    if (rx_q) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // status flags: a set always wins over a read clear
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_char <= 8'h00;
            rx_done <= 1'b0;
            overrun <= 1'b0;
            framing <= 1'b0;
            rx_break <= 1'b0;
        end else if (init_pulse) begin
            rx_done <= 1'b0;
            overrun <= 1'b0;
            framing <= 1'b0;
            rx_break <= 1'b0;
        end else if (char_evt) begin
            rx_char <= rx_shift;
            rx_done <= 1'b1;
            overrun <= rx_done & ~rd_rx_data;
            framing <= ~rx_q;
            rx_break <= 1'b0;
        end else begin
            rx_done <= rx_done & ~rd_rx_data;
            overrun <= overrun & ~rd_rx_data;
            framing <= framing & ~rd_rx_data;
            rx_break <= brk_evt | (rx_break & ~rd_rx_data);
        end
    end

    // ********************************************************
    // transmitter
    // ********************************************************
    wire tx_load = (tx_state == TX_IDLE) & ~tx_rdy;
    wire tx_line = (tx_state == TX_SHIFT) ? tx_frame[0] : 1'b1;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_buf <= 8'h00;
            tx_rdy <= 1'b1;
        end else if (init_pulse) begin
            tx_rdy <= 1'b1;
        end else if (wr_tx_data) begin
            tx_buf <= i_avs.writedata[7:0];
            tx_rdy <= 1'b0;
        end else if (tx_load) begin
            tx_rdy <= 1'b1;
        end
    end

    // shifter keeps running under break so dummy characters time it
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state <= TX_IDLE;
            tx_frame <= 10'h3FF;
            tx_bit_cnt <= 4'h0;
            tx_tick_cnt <= 4'h0;
        end else if (init_pulse) begin
            tx_state <= TX_IDLE;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_frame <= {1'b1, tx_buf, 1'b0};
                        tx_bit_cnt <= 4'h0;
                        tx_tick_cnt <= 4'h0;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (ovs_tick) begin
                        tx_tick_cnt <= tx_tick_cnt + 4'h1;
                        if (tx_tick_cnt == OVS_LAST) begin
                            tx_frame <= {1'b1, tx_frame[9:1]};
                            tx_bit_cnt <= tx_bit_cnt + 4'h1;
                            if (tx_bit_cnt == FRAME_LAST) begin
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // break takes hold only between characters, then pins space
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            brk_hold <= 1'b0;
            o_serial_out <= 1'b1;
        end else begin
            brk_hold <= tx_break & (brk_hold | (tx_state == TX_IDLE));
            o_serial_out <= brk_hold ? 1'b0 : tx_line;
        end
    end

    // ********************************************************
    // control registers and interrupt requests
    // ********************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            receive_interrupt_enable <= 1'b0;
            transmit_interrupt_enable <= 1'b0;
            loopback <= 1'b0;
            tx_break <= 1'b0;
        end else if (init_pulse) begin
            receive_interrupt_enable <= 1'b0;
            transmit_interrupt_enable <= 1'b0;
            loopback <= 1'b0;
            tx_break <= 1'b0;
        end else if (wr_ok & hit_rx_ctl) begin
            receive_interrupt_enable <= i_avs.writedata[`CSL_BIT_IRQ_EN];
        end else if (wr_ok & hit_tx_ctl) begin
            transmit_interrupt_enable <= i_avs.writedata[`CSL_BIT_IRQ_EN];
            loopback <= i_avs.writedata[`CSL_BIT_LOOPBACK];
            tx_break <= i_avs.writedata[`CSL_BIT_TX_BREAK];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_irq <= 1'b0;
            o_tx_irq <= 1'b0;
        end else begin
            o_rx_irq <= receive_interrupt_enable & rx_done;
            o_tx_irq <= transmit_interrupt_enable & tx_rdy;
        end
    end

    // read words; every bit not named here stays zero
    always_comb begin
        rx_ctl_word = 32'h0000_0000;
        rx_ctl_word[`CSL_BIT_RX_DONE] = rx_done;
        rx_ctl_word[`CSL_BIT_IRQ_EN] = receive_interrupt_enable;
        rx_data_word = 32'h0000_0000;
        rx_data_word[`CSL_CHAR_MSB:0] = rx_char;
        rx_data_word[`CSL_BIT_ERR_SUM] = overrun | framing;
        rx_data_word[`CSL_BIT_OVERRUN] = overrun;
        rx_data_word[`CSL_BIT_FRAMING] = framing;
        rx_data_word[`CSL_BIT_RX_BREAK] = rx_break;
        tx_ctl_word = 32'h0000_0000;
        tx_ctl_word[`CSL_BIT_TX_READY] = tx_rdy;
        tx_ctl_word[`CSL_BIT_IRQ_EN] = transmit_interrupt_enable;
        tx_ctl_word[`CSL_BIT_LOOPBACK] = loopback;
        tx_ctl_word[`CSL_BIT_TX_BREAK] = tx_break;
    end

    wire [31:0] rd_mux = hit_rx_ctl ? rx_ctl_word :
        hit_rx_data ? rx_data_word :
        hit_tx_ctl ? tx_ctl_word : 32'h0000_0000;

    // one wait state: answer captured on the first edge, taken
    // on the second; unmapped addresses read zero
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else if (bus_ack) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= i_avs.read ? rd_mux : 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    chk_upper_zero: assert property (
        rd_rx_data |=> o_avs_readdata[31:16] == 16'h0000)
        else $error("receive data upper half not zero");
    chk_err_summary: assert property (
        rd_rx_data |=> o_avs_readdata[15] ==
            (o_avs_readdata[14] | o_avs_readdata[13]))
        else $error("summary error mismatch");
    chk_overrun_set: assert property (
        char_evt && rx_done && !rd_rx_data && !init_pulse |=> overrun)
        else $error("overrun not flagged");
    chk_framing_eval: assert property (
        char_evt && !init_pulse |=> framing == !$past(rx_q))
        else $error("framing flag wrong");
    chk_read_clears: assert property (
        rd_rx_data && !char_evt && !brk_evt |=>
            !overrun && !framing && !rx_break && !rx_done)
        else $error("read did not clear flags");
    chk_break_set: assert property (
        brk_evt && !init_pulse |=> rx_break)
        else $error("break not flagged");
    chk_ready_clear: assert property (
        wr_tx_data && !init_pulse |=> !tx_rdy ##1 tx_state == TX_SHIFT)
        else $error("ready did not drop or load");
    chk_reset_state: assert property (
        init_pulse |=> tx_rdy && !transmit_interrupt_enable && !loopback && !tx_break
            && !overrun && !framing && !rx_break)
        else $error("supply drop did not initialise");
    chk_tx_irq: assert property (
        transmit_interrupt_enable && tx_rdy |=> o_tx_irq)
        else $error("transmit interrupt missing");
    chk_rx_irq: assert property (
        receive_interrupt_enable && rx_done |=> o_rx_irq)
        else $error("receive interrupt missing");
    chk_break_line: assert property (
        brk_hold |=> !o_serial_out)
        else $error("break not holding space");
    chk_start_bit: assert property (
        tx_state == TX_IDLE ##1 tx_state == TX_SHIFT |-> ##1 !o_serial_out)
        else $error("start bit not low");

    cov_char_rx: cover property (char_evt ##1 rd_rx_data);
    cov_overrun: cover property (char_evt && rx_done);
    cov_break: cover property (brk_evt);
    cov_tx_break: cover property (brk_hold && tx_state == TX_SHIFT);

endmodule : console_serial_line_unit

`default_nettype wire

// file: csl_terminal.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// console terminal at the far end of the line
// ****************************************
module csl_terminal #(
    parameter int BIT_CLKS = 256
) (
    input wire logic i_clk_sys,
    input wire logic i_line_from_dut,
    output logic o_line_to_dut
);
    logic [7:0] last_char;
    int char_count;
    int bit_clks;

    // bit length may be changed by the bench between characters
    initial begin
        o_line_to_dut = 1'b1;
        last_char = 8'h00;
        char_count = 0;
        bit_clks = BIT_CLKS;
    end

    // frame: low start, lsb first, stop level chosen by caller
    task automatic send(input logic [7:0] c, input logic stop);
        logic [9:0] f;
        f = {stop, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk_sys);
            o_line_to_dut <= f[i];
            repeat (bit_clks - 1) @(posedge i_clk_sys);
        end
        // a bad stop bit is followed by a mark bit
        @(posedge i_clk_sys);
        o_line_to_dut <= 1'b1;
        repeat (bit_clks - 1) @(posedge i_clk_sys);
    endtask : send

    // holds the line at a level, used for break and space
    task automatic set_line(input logic v);
        @(posedge i_clk_sys);
        o_line_to_dut <= v;
    endtask : set_line

    // sample mid bit; frames with a low stop are not counted
    always begin : rx_walk
        logic [7:0] c;
        @(negedge i_line_from_dut);
        repeat (bit_clks / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge i_clk_sys);
            c[i] = i_line_from_dut;
        end
        repeat (bit_clks) @(posedge i_clk_sys);
        if (i_line_from_dut === 1'b1) begin
            last_char = c;
            char_count++;
        end
    end
endmodule : csl_terminal

`default_nettype wire

// file: test_console_serial_line_unit.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench for the console serial line unit
// ****************************************
module test_console_serial_line_unit;
    import csl_pkg::*;
    localparam int BIT = 256;
    logic i_clk_sys, i_rst_b, i_supply_good, i_proc_halted;
    logic [2:0] i_baud_code;
    avs_req_t i_avs;
    logic [31:0] o_avs_readdata, rd;
    logic o_avs_waitrequest, o_serial_out, o_rx_irq, o_tx_irq, line_in;
    int mismatches, check_count;

    // short divider keeps a bit at 256 clocks
    console_serial_line_unit #(.DIV_AT_MIN(16)) dut_u (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_avs(i_avs),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_supply_good(i_supply_good),
        .i_proc_halted(i_proc_halted),
        .i_baud_code(i_baud_code),
        .i_serial_in(line_in),
        .o_serial_out(o_serial_out),
        .o_rx_irq(o_rx_irq),
        .o_tx_irq(o_tx_irq)
    );

    csl_terminal #(.BIT_CLKS(BIT)) term_u (
        .i_clk_sys(i_clk_sys),
        .i_line_from_dut(o_serial_out),
        .o_line_to_dut(line_in)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // ****************************************
    // reporting
    // ****************************************
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    // ****************************************
    // avalon master, request held until waitrequest low
    // ****************************************
    task automatic access(input logic is_rd, input logic [3:0] adr,
        input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_avs <= '{is_rd, ~is_rd, adr, 4'hF, wdata};
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        rd = o_avs_readdata;
        i_avs <= '0;
        if (o_avs_waitrequest !== 1'b0) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : access

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        access(1'b0, a, d);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        access(1'b1, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    // bounded wait for the terminal to collect n characters
    task automatic wait_chars(input int n);
        int k;
        k = 0;
        while (term_u.char_count < n && k < 40 * BIT) begin
            @(posedge i_clk_sys);
            k++;
        end
        if (term_u.char_count < n) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : wait_chars

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_rst_b = 1'b0;
        i_avs = '0;
        i_supply_good = 1'b1;
        i_proc_halted = 1'b0;
        i_baud_code = 3'h0;
        mismatches = 0;
        check_count = 0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        rd_chk(4'h8, 32'h0000_0080);
        rd_chk(4'h4, 32'h0000_0000);
        rd_chk(4'h0, 32'h0000_0000);
        rd_chk(4'h2, 32'h0000_0000);
        // second load while shifting keeps ready low
        wr(4'hC, 32'hFFFF_FF5A);
        wr(4'hC, 32'h0000_00A7);
        rd_chk(4'h8, 32'h0000_0000);
        rd_chk(4'hC, 32'h0000_0000);
        wait_chars(1);
        check({24'h0, term_u.last_char}, 32'h0000_005A);
        wait_chars(2);
        check({24'h0, term_u.last_char}, 32'h0000_00A7);
        rd_chk(4'h8, 32'h0000_0080);
        // receive, then read clears done
        term_u.send(8'hA5, 1'b1);
        rd_chk(4'h0, 32'h0000_0080);
        rd_chk(4'h4, 32'h0000_00A5);
        rd_chk(4'h0, 32'h0000_0000);
        // unread character overwritten
        term_u.send(8'h3C, 1'b1);
        term_u.send(8'hC3, 1'b1);
        rd_chk(4'h4, 32'h0000_C0C3);
        rd_chk(4'h4, 32'h0000_00C3);
        // bad stop, then a good one re-evaluates the flags
        term_u.send(8'h33, 1'b0);
        rd_chk(4'h4, 32'h0000_A033);
        term_u.send(8'h66, 1'b0);
        term_u.send(8'h44, 1'b1);
        rd_chk(4'h4, 32'h0000_C044);
        // 22 bit times of space
        term_u.set_line(1'b0);
        repeat (22 * BIT) @(posedge i_clk_sys);
        term_u.set_line(1'b1);
        repeat (2 * BIT) @(posedge i_clk_sys);
        rd_chk(4'h4, 32'h0000_A800);
        rd_chk(4'h4, 32'h0000_0000);
        // interrupt requests
        wr(4'h0, 32'h0000_0040);
        term_u.send(8'h12, 1'b1);
        check(32'(o_rx_irq), 32'h1);
        rd_chk(4'h4, 32'h0000_0012);
        repeat (2) @(posedge i_clk_sys);
        check(32'(o_rx_irq), 32'h0);
        check(32'(o_tx_irq), 32'h0);
        wr(4'h8, 32'h0000_0040);
        repeat (2) @(posedge i_clk_sys);
        check(32'(o_tx_irq), 32'h1);
        // loopback with the pin held at space
        wr(4'h8, 32'h0000_0004);
        term_u.set_line(1'b0);
        wr(4'hC, 32'h0000_003C);
        repeat (12 * BIT) @(posedge i_clk_sys);
        rd_chk(4'h4, 32'h0000_003C);
        term_u.set_line(1'b1);
        wait_chars(3);
        // break waits for the character in flight
        wr(4'hC, 32'h0000_0055);
        wr(4'h8, 32'h0000_0001);
        wait_chars(4);
        check({24'h0, term_u.last_char}, 32'h0000_0055);
        repeat (BIT) @(posedge i_clk_sys);
        check(32'(o_serial_out), 32'h0);
        wr(4'hC, 32'h0000_0077);
        repeat (12 * BIT) @(posedge i_clk_sys);
        rd_chk(4'h8, 32'h0000_0081);
        check(32'(o_serial_out), 32'h0);
        wr(4'h8, 32'h0000_0000);
        // break flop then output flop: the line is high after two edges,
        // so look one edge later, not in the edge that launches it
        repeat (3) @(posedge i_clk_sys);
        check(32'(o_serial_out), 32'h1);
        // faster rate on both ends; a wrong divider misreads the bits
        i_baud_code <= 3'h2;
        term_u.bit_clks = BIT / 4;
        term_u.send(8'h5C, 1'b1);
        rd_chk(4'h4, 32'h0000_005C);
        // supply drop while halted
        wr(4'h8, 32'h0000_0045);
        @(posedge i_clk_sys);
        i_proc_halted <= 1'b1;
        i_supply_good <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_supply_good <= 1'b1;
        i_proc_halted <= 1'b0;
        rd_chk(4'h8, 32'h0000_0080);
        rd_chk(4'h0, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : test_console_serial_line_unit

`default_nettype wire
